// ===== rtl/ncijfo_pkg.sv
/*
 * shared constants for the nibble processor core: opcodes, widths,
 * reset values and instruction cycle timing.
 * assumes a 200 MHz system clock and an eight-state instruction cycle.
 */
package ncijfo_pkg;

  localparam int unsigned NIB_W     = 4;
  localparam int unsigned PC_W      = 12;
  localparam int unsigned REG_COUNT = 16;
  localparam int unsigned REG_IDX_W = 4;
  localparam int unsigned STACK_LVL = 3;

  // upper opcode nibble values
  localparam logic [3:0] OP_SEND_FETCH = 4'h2;  // lsb 1: send select
  localparam logic [3:0] OP_JUMP_FETCH = 4'h3;  // lsb 1 jump, 0 fetch
  localparam logic [3:0] OP_CALL       = 4'h5;
  localparam logic [3:0] OP_INC        = 4'h6;
  localparam logic [3:0] OP_RET_LOAD   = 4'hc;

  // values after reset
  localparam logic [11:0] PC_RST    = 12'h000;
  localparam logic [3:0]  ACC_RST   = 4'h0;
  localparam logic        CARRY_RST = 1'b0;
  localparam logic [3:0]  NIB_RST   = 4'h0;

  // timing: two memory cycles of the fetch-indirect instruction
  localparam int unsigned CLK_PERIOD_NS   = 5;
  localparam int unsigned TWO_CYCLES_NS   = 21600;
  localparam int unsigned STATES_PER_CYC  = 8;
  localparam int unsigned STATE_CLKS =
    TWO_CYCLES_NS / (2 * STATES_PER_CYC * CLK_PERIOD_NS);
  localparam int unsigned TIMER_W = 9;
  localparam logic [8:0] STATE_LAST = 9'(STATE_CLKS - 1);
  localparam logic [8:0] TIMER_RST  = 9'h000;

  typedef enum logic [2:0] {
    PH_A1, PH_A2, PH_A3, PH_M1, PH_M2, PH_X1,
    PH_SECOND_OPERAND_STATE, PH_THIRD_OPERAND_STATE
  } ncijfo_phase_type;

endpackage : ncijfo_pkg

// ===== rtl/ncijfo_regfile.sv
/*
 * sixteen 4-bit index registers with one write port, one single read
 * port and one pair read port (even and odd register of the selected pair).
 * assumes writes are one-cycle strobes from the core.
 */
`timescale 1ns/100ps
module ncijfo_regfile (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       we_i,
  input  wire logic [3:0] waddr_i,
  input  wire logic [3:0] wdata_i,
  input  wire logic [3:0] raddr_i,
  output logic      [3:0] rdata_o,
  input  wire logic [2:0] pair_i,
  output logic      [3:0] pair_even_o,
  output logic      [3:0] pair_odd_o
);

  logic [3:0] regs [ncijfo_pkg::REG_COUNT];

  for (genvar g = 0; g < ncijfo_pkg::REG_COUNT; g++) begin : g_reg
    always_ff @(posedge clock_i) begin
      if (rst_i) begin
        regs[g] <= ncijfo_pkg::NIB_RST;
      end else if (we_i && (waddr_i == 4'(g))) begin
        regs[g] <= wdata_i;
      end
    end
  end

  assign rdata_o     = regs[raddr_i];
  assign pair_even_o = regs[{pair_i, 1'b0}];
  assign pair_odd_o  = regs[{pair_i, 1'b1}];

endmodule : ncijfo_regfile

// ===== rtl/ncijfo_stack.sv
/*
 * three-level address stack of 12-bit return addresses.
 * assumes push and pop are never asserted together; on overflow the
 * deepest entry is lost, on underflow the deepest entry repeats.
 */
`timescale 1ns/100ps
module ncijfo_stack (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        push_i,
  input  wire logic        pop_i,
  input  wire logic [11:0] push_data_i,
  output logic      [11:0] top_o
);

  logic [11:0] lvl [ncijfo_pkg::STACK_LVL];

  for (genvar g = 0; g < ncijfo_pkg::STACK_LVL; g++) begin : g_lvl
    always_ff @(posedge clock_i) begin
      if (rst_i) begin
        lvl[g] <= ncijfo_pkg::PC_RST;
      end else if (push_i) begin
        lvl[g] <= (g == 0) ? push_data_i : lvl[(g == 0) ? 0 : g - 1];
      end else if (pop_i && (g < ncijfo_pkg::STACK_LVL - 1)) begin
        lvl[g] <= lvl[(g < ncijfo_pkg::STACK_LVL - 1) ? g + 1 : g];
      end
    end
  end

  assign top_o = lvl[0];

endmodule : ncijfo_stack

// ===== rtl/ncijfo_core.sv
/*
 * nibble processor core executing increment, return-and-load, indirect
 * jump, send select, fetch indirect and subroutine call over a
 * multiplexed 4-bit data bus divided into eight timing states.
 * assumes memory chips drive the bus during the two fetch states and
 * latch the sent selection themselves; other opcodes act as no-ops.
 */
`timescale 1ns/100ps
module ncijfo_core (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] data_i,
  output logic      [3:0] data_o,
  output logic            data_oe_n_o,
  output logic            sync_o,
  output logic      [3:0] acc_o,
  output logic            carry_o
);

  ncijfo_pkg::ncijfo_phase_type phase;
  ncijfo_pkg::ncijfo_phase_type succ_phase;
  ncijfo_pkg::ncijfo_phase_type next_phase;

  logic [8:0]  timer;
  logic        advance;
  logic [11:0] pc;
  logic [3:0]  upper_opcode_nibble;
  logic [3:0]  lower_operand_nibble;
  logic [7:0]  call_target;
  logic        second_cycle;
  logic        next_second;
  logic        needs_second;
  logic [3:0]  acc;
  logic        carry;

  logic        is_inc;
  logic        is_ret;
  logic        is_jump;
  logic        is_send;
  logic        is_fetch;
  logic        is_call;

  logic        rf_we;
  logic [3:0]  rf_waddr;
  logic [3:0]  rf_wdata;
  logic [3:0]  rf_rdata;
  logic [2:0]  pair_sel;
  logic [3:0]  pair_even;
  logic [3:0]  pair_odd;

  logic        stack_push;
  logic        stack_pop;
  logic [11:0] stack_top;

  logic [3:0]  next_bus;
  logic        next_drive;

  // decode: upper nibble and, for send, jump and fetch, the lower nibble lsb select the operation
  assign is_inc   = upper_opcode_nibble == ncijfo_pkg::OP_INC;
  assign is_ret   = upper_opcode_nibble == ncijfo_pkg::OP_RET_LOAD;
  assign is_call  = upper_opcode_nibble == ncijfo_pkg::OP_CALL;
  assign is_jump  = (upper_opcode_nibble == ncijfo_pkg::OP_JUMP_FETCH)
                    && lower_operand_nibble[0];
  assign is_fetch = (upper_opcode_nibble == ncijfo_pkg::OP_JUMP_FETCH)
                    && !lower_operand_nibble[0];
  assign is_send  = (upper_opcode_nibble == ncijfo_pkg::OP_SEND_FETCH)
                    && lower_operand_nibble[0];
  assign needs_second = is_fetch || is_call;

  // timing state sequencer
  assign advance = timer == ncijfo_pkg::STATE_LAST;

  always_comb begin
    succ_phase = ncijfo_pkg::PH_A1;
    unique case (phase)
      ncijfo_pkg::PH_A1: succ_phase = ncijfo_pkg::PH_A2;
      ncijfo_pkg::PH_A2: succ_phase = ncijfo_pkg::PH_A3;
      ncijfo_pkg::PH_A3: succ_phase = ncijfo_pkg::PH_M1;
      ncijfo_pkg::PH_M1: succ_phase = ncijfo_pkg::PH_M2;
      ncijfo_pkg::PH_M2: succ_phase = ncijfo_pkg::PH_X1;
      ncijfo_pkg::PH_X1: succ_phase = ncijfo_pkg::PH_SECOND_OPERAND_STATE;
      ncijfo_pkg::PH_SECOND_OPERAND_STATE:
        succ_phase = ncijfo_pkg::PH_THIRD_OPERAND_STATE;
      ncijfo_pkg::PH_THIRD_OPERAND_STATE: succ_phase = ncijfo_pkg::PH_A1;
    endcase
  end

  assign next_phase = advance ? succ_phase : phase;

  // second cycle flag changes at the same edge as the move into A1,
  // so bus values for A1 must look at the coming value
  always_comb begin
    next_second = second_cycle;
    if (advance && (phase == ncijfo_pkg::PH_THIRD_OPERAND_STATE)) begin
      next_second = second_cycle ? 1'b0 : needs_second;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      timer <= ncijfo_pkg::TIMER_RST;
    end else if (advance) begin
      timer <= ncijfo_pkg::TIMER_RST;
    end else begin
      timer <= timer + 9'h001;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      phase <= ncijfo_pkg::PH_A1;
    end else begin
      phase <= next_phase;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      second_cycle <= 1'b0;
    end else begin
      second_cycle <= next_second;
    end
  end

  // instruction latch; the second word of a cycle pair is data instead
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      upper_opcode_nibble  <= ncijfo_pkg::NIB_RST;
      lower_operand_nibble <= ncijfo_pkg::NIB_RST;
    end else if (advance && !second_cycle) begin
      if (phase == ncijfo_pkg::PH_M1) begin
        upper_opcode_nibble <= data_i;
      end
      if (phase == ncijfo_pkg::PH_M2) begin
        lower_operand_nibble <= data_i;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      call_target <= 8'h00;
    end else if (advance && second_cycle && is_call) begin
      if (phase == ncijfo_pkg::PH_M1) begin
        call_target[7:4] <= data_i;
      end
      if (phase == ncijfo_pkg::PH_M2) begin
        call_target[3:0] <= data_i;
      end
    end
  end

  // pair zero addresses the fetched byte, otherwise the designated pair
  assign pair_sel = (next_second && is_fetch) ? 3'h0
                                              : lower_operand_nibble[3:1];

  // index register writes
  always_comb begin
    rf_we    = 1'b0;
    rf_waddr = lower_operand_nibble;
    rf_wdata = rf_rdata + 4'h1;
    if (advance && !second_cycle && is_inc
        && (phase == ncijfo_pkg::PH_X1)) begin
      rf_we = 1'b1;
    end
    if (advance && second_cycle && is_fetch) begin
      if (phase == ncijfo_pkg::PH_M1) begin
        rf_we    = 1'b1;
        rf_waddr = {lower_operand_nibble[3:1], 1'b0};
        rf_wdata = data_i;
      end
      if (phase == ncijfo_pkg::PH_M2) begin
        rf_we    = 1'b1;
        rf_waddr = {lower_operand_nibble[3:1], 1'b1};
        rf_wdata = data_i;
      end
    end
  end

  ncijfo_regfile u_regs (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .we_i        (rf_we),
    .waddr_i     (rf_waddr),
    .wdata_i     (rf_wdata),
    .raddr_i     (lower_operand_nibble),
    .rdata_o     (rf_rdata),
    .pair_i      (pair_sel),
    .pair_even_o (pair_even),
    .pair_odd_o  (pair_odd)
  );

  assign stack_push = advance && second_cycle && is_call
                      && (phase == ncijfo_pkg::PH_X1);
  assign stack_pop  = advance && !second_cycle && is_ret
                      && (phase == ncijfo_pkg::PH_X1);

  ncijfo_stack u_stack (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .push_i      (stack_push),
    .pop_i       (stack_pop),
    .push_data_i (pc),
    .top_o       (stack_top)
  );

  // counter steps after every fetched word except the data word of a fetch; the page nibble of a jump
  // or fetch is therefore already past a page-end location
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pc <= ncijfo_pkg::PC_RST;
    end else if (advance) begin
      if ((phase == ncijfo_pkg::PH_M2) && !(second_cycle && is_fetch)) begin
        pc <= pc + 12'h001;
      end else if ((phase == ncijfo_pkg::PH_X1) && !second_cycle
                   && is_jump) begin
        pc <= {pc[11:8], pair_even, pair_odd};
      end else if ((phase == ncijfo_pkg::PH_X1) && stack_pop) begin
        pc <= stack_top;
      end else if ((phase == ncijfo_pkg::PH_X1) && stack_push) begin
        pc <= {lower_operand_nibble, call_target};
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      acc <= ncijfo_pkg::ACC_RST;
    end else if (stack_pop) begin
      acc <= lower_operand_nibble;
    end
  end

  // none of these operations alter the carry
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      carry <= ncijfo_pkg::CARRY_RST;
    end else begin
      carry <= carry;
    end
  end

  // bus value for the state about to be entered, registered
  always_comb begin
    next_bus   = 4'h0;
    next_drive = 1'b0;
    unique case (next_phase)
      ncijfo_pkg::PH_A1: begin
        next_drive = 1'b1;
        next_bus   = (next_second && is_fetch) ? pair_odd : pc[3:0];
      end
      ncijfo_pkg::PH_A2: begin
        next_drive = 1'b1;
        next_bus   = (second_cycle && is_fetch) ? pair_even : pc[7:4];
      end
      ncijfo_pkg::PH_A3: begin
        next_drive = 1'b1;
        next_bus   = pc[11:8];
      end
      ncijfo_pkg::PH_SECOND_OPERAND_STATE: begin
        if (is_send && !second_cycle) begin
          next_drive = 1'b1;
          next_bus   = pair_even;
        end
      end
      ncijfo_pkg::PH_THIRD_OPERAND_STATE: begin
        if (is_send && !second_cycle) begin
          next_drive = 1'b1;
          next_bus   = pair_odd;
        end
      end
      ncijfo_pkg::PH_M1, ncijfo_pkg::PH_M2, ncijfo_pkg::PH_X1: begin
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      data_o      <= ncijfo_pkg::NIB_RST;
      data_oe_n_o <= 1'b1;
      sync_o      <= 1'b0;
    end else begin
      data_o      <= next_bus;
      data_oe_n_o <= !next_drive;
      sync_o      <= next_phase == ncijfo_pkg::PH_THIRD_OPERAND_STATE;
    end
  end

  assign acc_o   = acc;
  assign carry_o = carry;

endmodule : ncijfo_core

// ===== tb/ncijfo_props.sv
/* bus timing and operation checks on the core's ports.
   assumes one clock domain; bound below to every core instance. */
`timescale 1ns/100ps
module ncijfo_props (
  input wire logic       clock_i,
  input wire logic       rst_i,
  input wire logic [3:0] data_i,
  input wire logic [3:0] data_o,
  input wire logic       data_oe_n_o,
  input wire logic       sync_o,
  input wire logic [3:0] acc_o,
  input wire logic       carry_o
);
  logic [11:0] since;
  logic        seen;
  logic        sq;
  logic [3:0]  op_hi;
  logic [3:0]  op_lo;
  logic        second;
  logic        is_send;
  // second word of a call or the data cycle of a fetch is no opcode
  assign is_send = op_hi == 4'h2 && op_lo[0] && !second;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge clock_i) begin
    sq    <= sync_o;
    since <= (sync_o && !sq) ? 12'h000 : since + 12'h001;
    seen  <= rst_i ? 1'b0 : (seen || (sync_o && !sq));
  end
  // sampled mid-state, clear of the bus turn-around
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      op_hi  <= 4'h0;
      op_lo  <= 4'h0;
      second <= 1'b0;
    end else begin
      if (since == 12'h50a)
        second <= !second && (op_hi == 4'h5 || (op_hi == 4'h3 && !op_lo[0]));
      if (since == 12'h514) op_hi <= data_i;
      if (since == 12'h5dc) op_lo <= data_i;
    end
  end
  a_carry_kept: assert property ($stable(carry_o))
    else $error("carry flag changed");
  a_cycle_len: assert property (
    seen && $rose(sync_o) |-> since == 12'h86f)
    else $error("instruction cycle length wrong");
  a_state_len: assert property (
    seen && $fell(sync_o) |-> since == 12'h10d)
    else $error("timing state length wrong");
  a_addr_out: assert property (
    seen && since inside {[12'h110:12'h435]} |-> !data_oe_n_o)
    else $error("address not driven");
  a_mem_turn: assert property (
    seen && since inside {[12'h43a:12'h75f]} |-> data_oe_n_o)
    else $error("bus not released for memory");
  a_send_even: assert property (
    seen && since == 12'h76c && is_send |-> !data_oe_n_o)
    else $error("send select idle in second operand state");
  a_send_odd: assert property (
    seen && sync_o && is_send |-> !data_oe_n_o)
    else $error("send select idle in third operand state");
  a_x_release: assert property (
    seen && since == 12'h76c && !is_send |-> data_oe_n_o)
    else $error("bus driven by other operation");
  a_ret_acc: assert property (
    seen && since == 12'h79e && op_hi == 4'hc && !second
    |-> acc_o == op_lo)
    else $error("accumulator not loaded on return");
endmodule : ncijfo_props

bind ncijfo_core ncijfo_props u_props (.clock_i(clock_i), .rst_i(rst_i),
  .data_i(data_i), .data_o(data_o), .data_oe_n_o(data_oe_n_o),
  .sync_o(sync_o), .acc_o(acc_o), .carry_o(carry_o));

// ===== tb/ncijfo_rom_model.sv
/* program memory and selection latch facing the core's bus.
   assumes the bench loads mem before reset is released. */
`timescale 1ns/100ps
module ncijfo_rom_model (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  bus_i,
  input  wire logic        sync_i,
  input  wire logic        oe_n_i,
  output logic      [3:0]  data_o,
  output logic      [11:0] addr_o,
  output logic             addr_v_o,
  output logic      [7:0]  sel_o,
  output logic             sel_v_o,
  output logic      [1:0]  ram_chip_o,
  output logic      [1:0]  ram_reg_o,
  output logic      [3:0]  ram_char_o,
  output logic      [3:0]  rom_chip_o
);
  logic [7:0]  mem [0:4095];
  logic [11:0] cnt;
  logic        sq;
  logic        pend;
  logic [3:0]  hi;
  logic [7:0]  word;
  assign word       = mem[addr_o];
  assign ram_chip_o = sel_o[7:6];
  assign ram_reg_o  = sel_o[5:4];
  assign ram_char_o = sel_o[3:0];
  assign rom_chip_o = sel_o[7:4];
  always_ff @(posedge clock_i) begin
    sq <= sync_i;
    if (rst_i) cnt <= 12'h10d;
    else if (sync_i && !sq) cnt <= 12'h000;
    else cnt <= cnt + 12'h001;
  end
  // no pull on the bus: a moving pattern while nobody answers
  always_ff @(posedge clock_i) begin
    if (rst_i) data_o <= 4'h0;
    else if (cnt >= 12'h3e8 && cnt <= 12'h5c8) data_o <= word[7:4];
    else if (cnt > 12'h5c8 && cnt <= 12'h6a4) data_o <= word[3:0];
    else data_o <= cnt[3:0];
  end
  always_ff @(posedge clock_i) begin
    addr_v_o <= cnt == 12'h3ad;
    sel_v_o  <= 1'b0;
    if (cnt == 12'h190) addr_o[3:0] <= bus_i;
    if (cnt == 12'h29e) addr_o[7:4] <= bus_i;
    if (cnt == 12'h3ac) addr_o[11:8] <= bus_i;
    if (cnt == 12'h7d0) begin
      pend <= !oe_n_i;
      hi   <= bus_i;
    end
    if (cnt == 12'h064 && pend) begin
      sel_o   <= {hi, bus_i};
      sel_v_o <= 1'b1;
      pend    <= 1'b0;
    end
  end
endmodule : ncijfo_rom_model

// ===== tb/test_nibble_cpu_index_jump_fetch_ops.sv
/* self-checking bench: a small program runs from the memory model.
   assumes the core's bus contract; fetch and select events compared. */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  n_fail++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module test_nibble_cpu_index_jump_fetch_ops;
  logic        clock_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [3:0]  data_i;
  logic [3:0]  data_o;
  logic        data_oe_n_o;
  logic        sync_o;
  logic [3:0]  acc_o;
  logic        carry_o;
  logic [11:0] addr;
  logic        addr_v;
  logic [7:0]  sel;
  logic        sel_v;
  int          n_fail = 0;
  int          checks_done = 0;
  time         t0;
  logic [19:0] prog [28] = '{20'h00061, 20'h00121, 20'h00232, 20'h00323,
    20'h00453, 20'h00500, 20'h30033, 20'h32123, 20'h322c9, 20'h00651,
    20'h007f0, 20'h1f034, 20'h101ff, 20'h1f125, 20'h1f264, 20'h1f365,
    20'h1f425, 20'h1f551, 20'h1f6fe, 20'h1fe00, 20'h1ff36, 20'h201c7,
    20'h20027, 20'h1f721, 20'h1f852, 20'h1f9ff, 20'h2ff33, 20'h1fa00};
  always #2.5 clock_i = ~clock_i;
  ncijfo_core dut (.clock_i(clock_i), .rst_i(rst_i), .data_i(data_i),
    .data_o(data_o), .data_oe_n_o(data_oe_n_o), .sync_o(sync_o),
    .acc_o(acc_o), .carry_o(carry_o));
  ncijfo_rom_model u_rom (.clock_i(clock_i), .rst_i(rst_i),
    .bus_i(data_o), .sync_i(sync_o), .oe_n_i(data_oe_n_o),
    .data_o(data_i), .addr_o(addr), .addr_v_o(addr_v), .sel_o(sel),
    .sel_v_o(sel_v), .ram_chip_o(), .ram_reg_o(), .ram_char_o(),
    .rom_chip_o());
  // k = 1 waits for a sent selection, else for a fetch address
  task automatic ev(input logic k, input logic [11:0] e);
    int n;
    n = 0;
    @(posedge clock_i);
    while ((k ? sel_v : addr_v) !== 1'b1 && n < 4400) begin
      n++;
      @(posedge clock_i);
    end
    if (n >= 4400) begin
      n_fail++;
      $display("ERROR event wait expected pulse seen none");
    end
    `CHK(k ? "select" : "address", e, k ? {4'h0, sel} : addr)
  endtask : ev
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  task automatic t_inc_send;
    ev(0, 12'h000);
    ev(0, 12'h001);
    ev(1, 12'h001);
    $display("test inc_send done");
  endtask : t_inc_send
  task automatic t_fetch;
    ev(0, 12'h002);
    t0 = $time;
    ev(0, 12'h001);
    ev(0, 12'h003);
    `CHK("fetch time", 64'(ncijfo_pkg::TWO_CYCLES_NS), $time - t0)
    ev(1, 12'h021);
    $display("test fetch done");
  endtask : t_fetch
  task automatic t_jump_ret;
    ev(0, 12'h004);
    ev(0, 12'h005);
    ev(0, 12'h300);
    ev(0, 12'h321);
    ev(1, 12'h021);
    ev(0, 12'h322);
    ev(0, 12'h006);
    `CHK("acc", 4'h9, acc_o)
    $display("test jump_ret done");
  endtask : t_jump_ret
  task automatic t_wrap;
    ev(0, 12'h007);
    ev(0, 12'h1f0);
    ev(0, 12'h101);
    ev(1, 12'h0ff);
    ev(0, 12'h1f2);
    ev(0, 12'h1f3);
    ev(1, 12'h000);
    `CHK("carry", 1'b0, carry_o)
    $display("test wrap done");
  endtask : t_wrap
  task automatic t_page_fetch;
    ev(0, 12'h1f5);
    ev(0, 12'h1f6);
    ev(0, 12'h1fe);
    ev(0, 12'h1ff);
    ev(0, 12'h201);
    ev(0, 12'h200);
    ev(1, 12'h0c7);
    ev(0, 12'h201);
    ev(0, 12'h1f7);
    `CHK("acc", 4'h7, acc_o)
    ev(1, 12'h001);
    $display("test page_fetch done");
  endtask : t_page_fetch
  task automatic t_page_jump;
    ev(0, 12'h1f8);
    ev(0, 12'h1f9);
    ev(0, 12'h2ff);
    ev(0, 12'h321);
    ev(1, 12'h021);
    ev(0, 12'h322);
    ev(0, 12'h1fa);
    `CHK("acc", 4'h9, acc_o)
    $display("test page_jump done");
  endtask : t_page_jump
  initial begin
    foreach (prog[i]) u_rom.mem[prog[i][19:8]] = prog[i][7:0];
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    t_inc_send();
    t_fetch();
    t_jump_ret();
    t_wrap();
    t_page_fetch();
    t_page_jump();
    finish_test();
  end
  initial begin
    #450000;
    n_fail++;
    finish_test();
  end
endmodule : test_nibble_cpu_index_jump_fetch_ops
